// *** plee_pkg.sv ***
`default_nettype none
package plee_pkg;
    localparam int ENTRY_COUNT  = 512;
    localparam int ADDR_W       = 9;
    localparam int OP_W         = 5;
    localparam int ARG_W        = 8;
    localparam int ENTRY_W      = 13;
    localparam int FLAG_COUNT   = 64;
    localparam int SRC_COUNT    = 64;
    localparam int TIMER_COUNT  = 32;
    localparam int SHOT_COUNT   = 32;
    localparam int LATCH_COUNT  = 16;
    localparam int STACK_DEPTH  = 32;
    localparam int DEPTH_W      = 6;
    localparam int GATE_MIN     = 2;
    localparam int GATE_MAX     = 16;
    localparam int ARG_LO       = 0;
    localparam int OP_LO        = 8;
    localparam int CLK_MHZ      = 50;
    localparam int PASS_PERIOD_US  = 1000;
    localparam int PASS_PERIOD_CYC = PASS_PERIOD_US * CLK_MHZ;
    localparam int PASS_CNT_W   = 16;

    localparam logic [ENTRY_W-1:0] ENTRY_RESET = 13'h0000;

    localparam logic [OP_W-1:0] OP_END       = 5'h00;
    localparam logic [OP_W-1:0] OP_ON        = 5'h01;
    localparam logic [OP_W-1:0] OP_OFF       = 5'h02;
    localparam logic [OP_W-1:0] OP_RD_FLAG   = 5'h03;
    localparam logic [OP_W-1:0] OP_RD_REMOTE = 5'h04;
    localparam logic [OP_W-1:0] OP_RD_SWITCH = 5'h05;
    localparam logic [OP_W-1:0] OP_RD_ELEM   = 5'h06;
    localparam logic [OP_W-1:0] OP_NOT       = 5'h07;
    localparam logic [OP_W-1:0] OP_OR        = 5'h08;
    localparam logic [OP_W-1:0] OP_AND       = 5'h09;
    localparam logic [OP_W-1:0] OP_NOR       = 5'h0a;
    localparam logic [OP_W-1:0] OP_NAND      = 5'h0b;
    localparam logic [OP_W-1:0] OP_XOR       = 5'h0c;
    localparam logic [OP_W-1:0] OP_LATCH     = 5'h0d;
    localparam logic [OP_W-1:0] OP_TIMER     = 5'h0e;
    localparam logic [OP_W-1:0] OP_ASSIGN    = 5'h0f;
    localparam logic [OP_W-1:0] OP_SHOT_POS  = 5'h10;
    localparam logic [OP_W-1:0] OP_SHOT_NEG  = 5'h11;
    localparam logic [OP_W-1:0] OP_SHOT_DUAL = 5'h12;

    typedef enum logic [1:0] {
        PLEE_COMPILE,
        PLEE_IDLE,
        PLEE_EVAL
    } plee_state_t;
endpackage : plee_pkg
`default_nettype wire

// *** plee_operand.sv ***
`timescale 1ns/100ps
`default_nettype none
module plee_operand
    import plee_pkg::*;
(
    input  wire logic [plee_pkg::OP_W-1:0]      op_i,
    input  wire logic [plee_pkg::ARG_W-1:0]     arg_i,
    input  wire logic [plee_pkg::SRC_COUNT-1:0] remote_i,
    input  wire logic [plee_pkg::SRC_COUNT-1:0] switch_i,
    input  wire logic [plee_pkg::SRC_COUNT-1:0] switch_on_closed_i,
    input  wire logic [plee_pkg::SRC_COUNT-1:0] elem_state_i,
    input  wire logic [plee_pkg::SRC_COUNT-1:0] elem_en_i,
    input  wire logic [plee_pkg::FLAG_COUNT-1:0] flag_i,
    output logic                                bit_o
);
    logic [5:0] idx;

    assign idx = arg_i[5:0];

    always_comb begin
        case (op_i)
            OP_ON:        bit_o = 1'b1;
            OP_OFF:       bit_o = 1'b0;
            OP_RD_FLAG:   bit_o = flag_i[idx];
            OP_RD_REMOTE: bit_o = remote_i[idx];
            // Reads 1 when the input matches its switch_on_closed_i bit; polarity picks which level means on
            OP_RD_SWITCH: bit_o = ~(switch_i[idx] ^ switch_on_closed_i[idx]);
            OP_RD_ELEM:   bit_o = elem_state_i[idx] & elem_en_i[idx];
            default:      bit_o = 1'b0;
        endcase
    end
endmodule : plee_operand
`default_nettype wire

// *** plee_edge_bank.sv ***
`timescale 1ns/100ps
`default_nettype none
module plee_edge_bank
    import plee_pkg::*;
(
    input  wire logic                            mclk_i,
    input  wire logic                            nrst_i,
    input  wire logic                            ce_i,
    input  wire logic                            clr_i,
    input  wire logic                            fire_i,
    input  wire logic [4:0]                      idx_i,
    input  wire logic [plee_pkg::OP_W-1:0]       op_i,
    input  wire logic                            din_i,
    output logic                                 pulse_o
);
    logic [SHOT_COUNT-1:0] prev;

    // Each one-shot is seen once a pass, so prev holds last pass input
    always_comb begin
        case (op_i)
            OP_SHOT_POS:  pulse_o = din_i & ~prev[idx_i];
            OP_SHOT_NEG:  pulse_o = ~din_i & prev[idx_i];
            OP_SHOT_DUAL: pulse_o = din_i ^ prev[idx_i];
            default:      pulse_o = 1'b0;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            prev <= '0;
        end else if (ce_i) begin
            if (clr_i) begin
                prev <= '0;
            end else if (fire_i) begin
                prev[idx_i] <= din_i;
            end
        end
    end
endmodule : plee_edge_bank
`default_nettype wire

// *** plee_evaluator.sv ***
`timescale 1ns/100ps
`default_nettype none
module plee_evaluator
    import plee_pkg::*;
#(
    parameter int PASS_CYC = plee_pkg::PASS_PERIOD_CYC
)(
    input  wire logic                              mclk_i,
    input  wire logic                              nrst_i,
    input  wire logic                              ce_i,
    input  wire logic                              cfg_we_i,
    input  wire logic [plee_pkg::ADDR_W-1:0]       cfg_addr_i,
    input  wire logic [plee_pkg::ENTRY_W-1:0]      cfg_data_i,
    input  wire logic [plee_pkg::SRC_COUNT-1:0]    remote_i,
    input  wire logic [plee_pkg::SRC_COUNT-1:0]    switch_i,
    input  wire logic [plee_pkg::SRC_COUNT-1:0]    switch_on_closed_i,
    input  wire logic [plee_pkg::SRC_COUNT-1:0]    elem_state_i,
    input  wire logic [plee_pkg::SRC_COUNT-1:0]    elem_en_i,
    output logic      [plee_pkg::FLAG_COUNT-1:0]   flags_o,
    output logic      [plee_pkg::TIMER_COUNT-1:0]  timer_o,
    output logic                                   syntax_err_o,
    output logic                                   busy_o,
    output logic                                   pass_done_o
);
    import plee_pkg::*;

    logic [ENTRY_W-1:0]     store [ENTRY_COUNT];
    plee_state_t            st;
    logic [ADDR_W-1:0]      pc;
    logic [STACK_DEPTH-1:0] stk;
    logic [STACK_DEPTH-1:0] next_stk;
    logic [DEPTH_W-1:0]     depth;
    logic [FLAG_COUNT-1:0]  used_flag;
    logic [TIMER_COUNT-1:0] used_timer;
    logic [LATCH_COUNT-1:0] latch_q;
    logic [PASS_CNT_W-1:0]  pass_cnt;
    logic                   pass_due;

    logic [ENTRY_W-1:0]     cur;
    logic [OP_W-1:0]        op;
    logic [ARG_W-1:0]       arg;
    logic [4:0]             gate_n;
    logic [5:0]             fi;
    logic [4:0]             ti;
    logic [3:0]             li;
    logic                   last;
    logic                   stop;
    logic                   operand_bit;
    logic                   shot_pulse;
    logic                   latch_next;
    logic                   eval_go;
    logic                   comp_go;
    logic [5:0]             comp_need;
    logic [6:0]             comp_after;
    logic                   comp_bad;
    logic [STACK_DEPTH-1:0] mask;

    function automatic logic [STACK_DEPTH-1:0] top_mask(input logic [4:0] n);
        top_mask = (STACK_DEPTH'(1) << n) - STACK_DEPTH'(1);
    endfunction : top_mask

    // Pop n results and push v in their place
    function automatic logic [STACK_DEPTH-1:0] stk_put(
        input logic [STACK_DEPTH-1:0] s,
        input logic [4:0]             n,
        input logic                   v
    );
        stk_put = ((s >> n) << 1) | {{(STACK_DEPTH-1){1'b0}}, v};
    endfunction : stk_put

    // Results consumed by an entry; unknown codes ask for more than any depth
    function automatic logic [5:0] consumes(
        input logic [OP_W-1:0] o,
        input logic [4:0]      n
    );
        case (o)
            OP_ON, OP_OFF, OP_RD_FLAG, OP_RD_REMOTE,
            OP_RD_SWITCH, OP_RD_ELEM:            consumes = 6'h00;
            OP_NOT, OP_TIMER, OP_ASSIGN,
            OP_SHOT_POS, OP_SHOT_NEG, OP_SHOT_DUAL: consumes = 6'h01;
            OP_XOR, OP_LATCH:                    consumes = 6'h02;
            OP_OR, OP_AND, OP_NOR, OP_NAND: begin
                if (n < 5'(GATE_MIN) || n > 5'(GATE_MAX)) begin
                    consumes = 6'h3f;
                end else begin
                    consumes = {1'b0, n};
                end
            end
            default:                             consumes = 6'h3f;
        endcase
    endfunction : consumes

    assign cur    = store[pc];
    assign op     = cur[OP_LO +: OP_W];
    assign arg    = cur[ARG_LO +: ARG_W];
    assign gate_n = arg[4:0];
    assign fi     = arg[5:0];
    assign ti     = arg[4:0];
    assign li     = arg[3:0];
    assign last   = (pc == ADDR_W'(ENTRY_COUNT - 1));
    assign stop   = (op == OP_END) || last;
    assign mask   = top_mask(gate_n);
    assign eval_go = (st == PLEE_EVAL) && !cfg_we_i;
    assign comp_go = (st == PLEE_COMPILE) && !cfg_we_i && (op != OP_END);
    assign latch_next = ~stk[0] & (stk[1] | latch_q[li]);

    plee_operand u_operand (
        .op_i               (op),
        .arg_i              (arg),
        .remote_i           (remote_i),
        .switch_i           (switch_i),
        .switch_on_closed_i (switch_on_closed_i),
        .elem_state_i       (elem_state_i),
        .elem_en_i          (elem_en_i),
        .flag_i             (flags_o),
        .bit_o              (operand_bit)
    );

    plee_edge_bank u_edge (
        .mclk_i  (mclk_i),
        .nrst_i  (nrst_i),
        .ce_i    (ce_i),
        .clr_i   (st == PLEE_COMPILE),
        .fire_i  (eval_go && (op >= OP_SHOT_POS) && (op <= OP_SHOT_DUAL)),
        .idx_i   (arg[4:0]),
        .op_i    (op),
        .din_i   (stk[0]),
        .pulse_o (shot_pulse)
    );

    always_comb begin
        next_stk = stk;
        case (op)
            OP_ON, OP_OFF, OP_RD_FLAG, OP_RD_REMOTE, OP_RD_SWITCH, OP_RD_ELEM: begin
                next_stk = {stk[STACK_DEPTH-2:0], operand_bit};
            end
            OP_NOT:   next_stk = stk_put(stk, 5'd1, ~stk[0]);
            OP_OR:    next_stk = stk_put(stk, gate_n, |(stk & mask));
            OP_AND:   next_stk = stk_put(stk, gate_n, &(stk | ~mask));
            OP_NOR:   next_stk = stk_put(stk, gate_n, ~|(stk & mask));
            OP_NAND:  next_stk = stk_put(stk, gate_n, ~&(stk | ~mask));
            OP_XOR:   next_stk = stk_put(stk, 5'd2, stk[0] ^ stk[1]);
            OP_LATCH: next_stk = stk_put(stk, 5'd2, latch_next);
            // Delay settings are outside this block; the timer passes through
            OP_TIMER: next_stk = stk_put(stk, 5'd1, stk[0]);
            OP_SHOT_POS, OP_SHOT_NEG, OP_SHOT_DUAL: begin
                next_stk = stk_put(stk, 5'd1, shot_pulse);
            end
            OP_ASSIGN: next_stk = '0;
            default:  next_stk = stk;
        endcase
    end

    always_comb begin
        comp_need  = consumes(op, gate_n);
        comp_after = 7'(depth) - 7'(comp_need) + ((op == OP_ASSIGN) ? 7'd0 : 7'd1);
        comp_bad   = (comp_need > 6'(depth))
                   || (comp_after > 7'(STACK_DEPTH))
                   || ((op == OP_ASSIGN) && used_flag[fi])
                   || ((op == OP_TIMER) && used_timer[ti]);
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < ENTRY_COUNT; i++) begin
                store[i] <= ENTRY_RESET;
            end
        end else if (ce_i && cfg_we_i) begin
            store[cfg_addr_i] <= cfg_data_i;
        end
    end

    // Pass scheduler; a pass of 512 entries is far shorter than the period
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            pass_cnt <= '0;
            pass_due <= 1'b0;
        end else if (ce_i) begin
            if (pass_cnt == '0) begin
                pass_cnt <= PASS_CNT_W'(PASS_CYC - 1);
                pass_due <= 1'b1;
            end else begin
                pass_cnt <= pass_cnt - PASS_CNT_W'(1);
                if (st == PLEE_IDLE && !syntax_err_o && !cfg_we_i) begin
                    pass_due <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            st <= PLEE_COMPILE;
            pc <= '0;
        end else if (ce_i) begin
            if (cfg_we_i) begin
                st <= PLEE_COMPILE;
                pc <= '0;
            end else begin
                case (st)
                    PLEE_COMPILE: begin
                        if (comp_bad || stop) begin
                            st <= PLEE_IDLE;
                            pc <= '0;
                        end else begin
                            pc <= pc + ADDR_W'(1);
                        end
                    end
                    PLEE_IDLE: begin
                        if (pass_due && !syntax_err_o) begin
                            st <= PLEE_EVAL;
                        end
                        pc <= '0;
                    end
                    PLEE_EVAL: begin
                        if (stop) begin
                            st <= PLEE_IDLE;
                            pc <= '0;
                        end else begin
                            pc <= pc + ADDR_W'(1);
                        end
                    end
                    default: begin
                        st <= PLEE_COMPILE;
                        pc <= '0;
                    end
                endcase
            end
        end
    end

    // Compile check; a bad list never runs until it is rewritten
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            depth        <= '0;
            used_flag    <= '0;
            used_timer   <= '0;
            syntax_err_o <= 1'b0;
        end else if (ce_i) begin
            if (cfg_we_i) begin
                depth        <= '0;
                used_flag    <= '0;
                used_timer   <= '0;
                syntax_err_o <= 1'b0;
            end else if (comp_go) begin
                if (comp_bad) begin
                    syntax_err_o <= 1'b1;
                end else begin
                    depth <= (op == OP_ASSIGN) ? '0 : DEPTH_W'(comp_after);
                    if (op == OP_ASSIGN) begin
                        used_flag[fi] <= 1'b1;
                    end
                    if (op == OP_TIMER) begin
                        used_timer[ti] <= 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            stk <= '0;
        end else if (ce_i) begin
            if (eval_go) begin
                stk <= next_stk;
            end else begin
                stk <= '0;
            end
        end
    end

    // Flags update in place, so earlier readers see the previous pass
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            flags_o <= '0;
        end else if (ce_i) begin
            if (st == PLEE_COMPILE) begin
                flags_o <= '0;
            end else if (eval_go && op == OP_ASSIGN) begin
                flags_o[fi] <= stk[0];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            latch_q <= '0;
        end else if (ce_i) begin
            if (st == PLEE_COMPILE) begin
                latch_q <= '0;
            end else if (eval_go && op == OP_LATCH) begin
                latch_q[li] <= latch_next;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            timer_o <= '0;
        end else if (ce_i) begin
            if (st == PLEE_COMPILE) begin
                timer_o <= '0;
            end else if (eval_go && op == OP_TIMER) begin
                timer_o[ti] <= stk[0];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            busy_o      <= 1'b1;
            pass_done_o <= 1'b0;
        end else if (ce_i) begin
            busy_o      <= cfg_we_i || (st == PLEE_COMPILE);
            pass_done_o <= eval_go && stop;
        end
    end

    default clocking dflt_cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    end_stops_a: assert property (ce_i && eval_go && op == OP_END
        |=> st == PLEE_IDLE && pass_done_o && pc == '0)
        else $error("terminator did not end the pass");
    order_step_a: assert property (ce_i && eval_go && !stop
        |=> pc == $past(pc) + ADDR_W'(1) && st == PLEE_EVAL)
        else $error("entries not taken in order");
    assign_flag_a: assert property (ce_i && eval_go && op == OP_ASSIGN
        |=> flags_o[$past(fi)] == $past(stk[0]) && stk == '0)
        else $error("assignment did not store result and end equation");
    not_inv_a: assert property (ce_i && eval_go && op == OP_NOT
        |=> stk[0] == !$past(stk[0]) && stk[31:1] == $past(stk[31:1]))
        else $error("inverter touched more than the top result");
    latch_rdom_a: assert property (ce_i && eval_go && op == OP_LATCH && stk[0]
        |=> !stk[0] && !latch_q[$past(li)])
        else $error("latch not reset dominant");
    xor_two_a: assert property (ce_i && eval_go && op == OP_XOR
        |=> stk[0] == ($past(stk[0]) != $past(stk[1])))
        else $error("exclusive-or result wrong");
    and_gate_a: assert property (ce_i && eval_go && op == OP_AND
        |=> stk[0] == &($past(stk) | ~$past(mask)))
        else $error("and gate result wrong");
    dup_reject_a: assert property (ce_i && comp_go && op == OP_ASSIGN && used_flag[fi]
        |=> syntax_err_o && st == PLEE_IDLE)
        else $error("duplicate assignment not rejected");
    compile_clr_a: assert property (ce_i && st == PLEE_COMPILE && !cfg_we_i
        |=> latch_q == '0 && flags_o == '0)
        else $error("latches not cleared on recompile");
    pass_start_a: assert property (ce_i && st == PLEE_IDLE && pass_due
        && !syntax_err_o && !cfg_we_i |=> st == PLEE_EVAL)
        else $error("due pass did not start");

    pass_end_c: cover property (ce_i && eval_go && op == OP_END);
    syn_err_c: cover property (ce_i && comp_go && comp_bad);
    latch_set_c: cover property (ce_i && eval_go && op == OP_LATCH && latch_next);
    shot_fire_c: cover property (ce_i && eval_go && op == OP_SHOT_POS && shot_pulse);
endmodule : plee_evaluator
`default_nettype wire

// *** plee_evaluator_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module plee_evaluator_test;
    import plee_pkg::*;
    // Short pass period keeps the run small; must exceed list length plus two
    localparam int PCYC = 100;
    logic                     mclk_i             = 1'b0;
    logic                     nrst_i             = 1'b0;
    logic                     cfg_we_i           = 1'b0;
    logic [ADDR_W-1:0]        cfg_addr_i         = '0;
    logic [ENTRY_W-1:0]       cfg_data_i         = '0;
    logic [SRC_COUNT-1:0]     remote_i           = '0;
    logic [SRC_COUNT-1:0]     switch_i           = '0;
    logic [SRC_COUNT-1:0]     switch_on_closed_i = '0;
    logic [SRC_COUNT-1:0]     elem_state_i       = '0;
    logic [SRC_COUNT-1:0]     elem_en_i          = '0;
    logic [FLAG_COUNT-1:0]    flags_o;
    logic [TIMER_COUNT-1:0]   timer_o;
    logic                     syntax_err_o;
    logic                     busy_o;
    logic                     pass_done_o;
    int                       failures           = 0;
    int                       compares           = 0;

    plee_evaluator #(.PASS_CYC(PCYC)) u_dut (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(1'b1), .cfg_we_i(cfg_we_i),
        .cfg_addr_i(cfg_addr_i), .cfg_data_i(cfg_data_i), .remote_i(remote_i),
        .switch_i(switch_i), .switch_on_closed_i(switch_on_closed_i),
        .elem_state_i(elem_state_i), .elem_en_i(elem_en_i), .flags_o(flags_o),
        .timer_o(timer_o), .syntax_err_o(syntax_err_o), .busy_o(busy_o),
        .pass_done_o(pass_done_o)
    );

    always #10 mclk_i = ~mclk_i;

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    task automatic wait_idle;
        int i;
        for (i = 0; i < 600 && busy_o !== 1'b0; i++) @(negedge mclk_i);
        if (busy_o !== 1'b0) begin
            failures++;
            stop_test();
        end
    endtask : wait_idle

    // Returns at the falling edge of the pass_done_o pulse cycle
    task automatic wait_pass(output int n);
        @(negedge mclk_i);
        for (n = 1; n < 3 * PCYC && pass_done_o !== 1'b1; n++) @(negedge mclk_i);
        if (pass_done_o !== 1'b1) begin
            failures++;
            stop_test();
        end
    endtask : wait_pass

    // One idle cycle between writes so the strobe is never set twice in a step
    task automatic prog(input logic [ENTRY_W-1:0] q[$]);
        foreach (q[k]) begin
            @(negedge mclk_i);
            cfg_we_i   = 1'b1;
            cfg_addr_i = ADDR_W'(k);
            cfg_data_i = q[k];
            @(negedge mclk_i);
            cfg_we_i   = 1'b0;
        end
        wait_idle();
    endtask : prog

    task automatic t_reset;
        int n;
        check(busy_o, 1);
        check(flags_o, 0);
        @(negedge mclk_i);
        nrst_i = 1'b1;
        wait_idle();
        wait_pass(n);
        wait_pass(n);
        check(n <= PCYC, 1);
        check(syntax_err_o, 0);
        check(flags_o, 0);
        $display("reset test done");
    endtask : t_reset

    task automatic t_gates;
        int n;
        switch_i           = 64'h1;
        switch_on_closed_i = 64'h1;
        remote_i           = 64'h1;
        prog('{{OP_RD_REMOTE, 8'h00}, {OP_RD_SWITCH, 8'h00}, {OP_NOT, 8'h00},
               {OP_AND, 8'h02}, {OP_ASSIGN, 8'h00}, {OP_ON, 8'h00}, {OP_OFF, 8'h00},
               {OP_XOR, 8'h00}, {OP_ASSIGN, 8'h01}, {OP_RD_SWITCH, 8'h01},
               {OP_ASSIGN, 8'h03}, {OP_OFF, 8'h00}, {OP_ON, 8'h00}, {OP_ON, 8'h00},
               {OP_ON, 8'h00}, {OP_AND, 8'h03}, {OP_ASSIGN, 8'h04}, {OP_OFF, 8'h00},
               {OP_ON, 8'h00}, {OP_OR, 8'h02}, {OP_ASSIGN, 8'h0c}, {OP_OFF, 8'h00},
               {OP_OFF, 8'h00}, {OP_NOR, 8'h02}, {OP_ASSIGN, 8'h0d}, {OP_ON, 8'h00},
               {OP_ON, 8'h00}, {OP_NAND, 8'h02}, {OP_ASSIGN, 8'h0e}, {OP_END, 8'h00},
               {OP_ON, 8'h00}, {OP_ASSIGN, 8'h06}});
        check(syntax_err_o, 0);
        wait_pass(n);
        check(flags_o, 64'h301a);
        wait_pass(n);
        switch_i = 64'h0;
        wait_pass(n);
        check(flags_o, 64'h301b);
        $display("gate test done");
    endtask : t_gates

    task automatic t_latch;
        int n;
        remote_i = 64'h2;
        prog('{{OP_RD_REMOTE, 8'h01}, {OP_RD_REMOTE, 8'h02}, {OP_LATCH, 8'h00},
               {OP_ASSIGN, 8'h02}, {OP_RD_REMOTE, 8'h01}, {OP_TIMER, 8'h03},
               {OP_ASSIGN, 8'h05}, {OP_END, 8'h00}});
        wait_pass(n);
        check({timer_o[3], flags_o[5], flags_o[2]}, 3'h7);
        remote_i = 64'h0;
        wait_pass(n);
        wait_pass(n);
        check({timer_o[3], flags_o[5], flags_o[2]}, 3'h1);
        remote_i = 64'h6;
        wait_pass(n);
        wait_pass(n);
        check(flags_o[2], 0);
        remote_i = 64'h2;
        wait_pass(n);
        wait_pass(n);
        remote_i = 64'h0;
        prog('{{OP_RD_REMOTE, 8'h01}});
        wait_pass(n);
        check(flags_o[2], 0);
        $display("latch test done");
    endtask : t_latch

    task automatic t_feedback;
        int n;
        remote_i     = 64'h30;
        elem_state_i = 64'h18;
        elem_en_i    = 64'h10;
        prog('{{OP_RD_FLAG, 8'h08}, {OP_ASSIGN, 8'h07}, {OP_RD_REMOTE, 8'h04},
               {OP_ASSIGN, 8'h08}, {OP_RD_ELEM, 8'h03}, {OP_ASSIGN, 8'h0a},
               {OP_RD_ELEM, 8'h04}, {OP_ASSIGN, 8'h0b}, {OP_RD_REMOTE, 8'h05},
               {OP_SHOT_POS, 8'h00}, {OP_ASSIGN, 8'h09}, {OP_RD_REMOTE, 8'h05},
               {OP_SHOT_NEG, 8'h01}, {OP_ASSIGN, 8'h0c}, {OP_RD_REMOTE, 8'h05},
               {OP_SHOT_DUAL, 8'h02}, {OP_ASSIGN, 8'h0d}, {OP_END, 8'h00}});
        wait_pass(n);
        // History starts cleared after a compile, so a high input is an edge
        check(flags_o[11:7], 5'h16);
        check({flags_o[13:12], flags_o[9]}, 3'h5);
        wait_pass(n);
        check(flags_o[11:7], 5'h13);
        remote_i = 64'h00;
        wait_pass(n);
        check({flags_o[13:12], flags_o[9]}, 3'h6);
        remote_i = 64'h20;
        wait_pass(n);
        check({flags_o[13:12], flags_o[9]}, 3'h5);
        wait_pass(n);
        check({flags_o[13:12], flags_o[9]}, 3'h0);
        $display("feedback test done");
    endtask : t_feedback

    task automatic t_errors;
        prog('{{OP_ON, 8'h00}, {OP_ASSIGN, 8'h00}, {OP_ON, 8'h00}, {OP_ASSIGN, 8'h00}});
        check(syntax_err_o, 1);
        prog('{{OP_ON, 8'h00}, {OP_TIMER, 8'h01}, {OP_TIMER, 8'h01}, {OP_END, 8'h00}});
        check(syntax_err_o, 1);
        prog('{{OP_ON, 8'h00}, {OP_ON, 8'h00}, {OP_OR, 8'h01}});
        check(syntax_err_o, 1);
        prog('{{OP_ON, 8'h00}, {OP_END, 8'h00}});
        check(syntax_err_o, 0);
        prog('{{OP_NOT, 8'h00}});
        check(syntax_err_o, 1);
        $display("error test done");
    endtask : t_errors

    initial begin
        repeat (20) @(negedge mclk_i);
        t_reset();
        t_gates();
        t_latch();
        t_feedback();
        t_errors();
        stop_test();
    end
endmodule : plee_evaluator_test
`default_nettype wire
